// ### sfm_defines.svh
// Constants for the manual SPI frame sequencer
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH
// Lane width codes
`define SFM_LANES_1 2'h0
`define SFM_LANES_4 2'h2
// Address output codes
`define SFM_ADDR_NONE 4'h0
`define SFM_ADDR_24 4'h7
`define SFM_ADDR_32 4'hf
// Option byte output codes
`define SFM_OPD_NONE 4'h0
`define SFM_OPD_3 4'h8
`define SFM_OPD_32 4'hc
`define SFM_OPD_321 4'he
`define SFM_OPD_3210 4'hf
// Transfer data length codes
`define SFM_DATA_NONE 4'h0
`define SFM_DATA_8 4'h8
`define SFM_DATA_16 4'hc
`define SFM_DATA_32 4'hf
// Reset values
`define SFM_RST_LANES 4'h0
`define SFM_RST_CS 1'b1
`endif

// ### sfm_pkg.sv
// Types for the manual SPI frame sequencer
`default_nettype none
package sfm_pkg;
  typedef enum logic [6:0] {
    SFM_IDLE = 7'b0000001,
    SFM_CMD  = 7'b0000010,
    SFM_OCMD = 7'b0000100,
    SFM_ADDR = 7'b0001000,
    SFM_OPT  = 7'b0010000,
    SFM_DATA = 7'b0100000,
    SFM_DONE = 7'b1000000
  } sfm_state_e;
endpackage
`default_nettype wire

// ### sfm_frame.sv
// Manual SPI frame sequencer: command, option command, address, option bytes, data
`timescale 1ns/10ps
`default_nettype none
`include "sfm_defines.svh"

// Summary of operation
// - Command phase uses one or four lanes
// - Optional command lanes chosen by own field
// - Address phase lanes chosen by field
// - Option bytes lanes chosen by field
// - Transfer data lanes chosen by field
// - Command flag includes or omits command
// - Optional command flag includes or omits it
// - Address none, 24 or 32 bits
// - Option bytes none, 3, 32, 321, 3210
// - Data disabled means no data phase
// - Data length 8, 16 or 32 bits, doubled when DOUBLE_IN is set
// - Hold clear releases select at end
// - Hold set keeps select until next
module sfm_frame
  import sfm_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic START_IN,
  input wire logic CMD_EN_IN,
  input wire logic OCMD_EN_IN,
  input wire logic [3:0] ADDR_EN_IN,
  input wire logic [3:0] OPT_EN_IN,
  input wire logic [3:0] DATA_EN_IN,
  input wire logic DOUBLE_IN,
  input wire logic [1:0] CMD_LANES_IN,
  input wire logic [1:0] OCMD_LANES_IN,
  input wire logic [1:0] ADDR_LANES_IN,
  input wire logic [1:0] OPT_LANES_IN,
  input wire logic [1:0] DATA_LANES_IN,
  input wire logic HOLD_CS_IN,
  input wire logic [7:0] CMD_IN,
  input wire logic [7:0] OCMD_IN,
  input wire logic [31:0] ADDR_IN,
  input wire logic [31:0] OPT_IN,
  input wire logic [63:0] WDATA_IN,
  input wire logic [3:0] IO_IN,
  output logic CS_N_OUT,
  output logic SCK_OUT,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE_OUT,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic [63:0] RDATA_OUT
);

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  // Bits moved per clock for a lane code
  function automatic logic [6:0] step_of(input logic [1:0] lanes);
    step_of = (lanes == `SFM_LANES_4) ? 7'h04 : 7'h01;
  endfunction

  sfm_state_e state_ff, nxt_state;
  logic [6:0] cnt_ff, nxt_cnt;
  logic [6:0] len_ff, nxt_len;
  logic [63:0] sh_ff, nxt_sh;
  logic [63:0] rd_ff, nxt_rd;
  logic [1:0] lanes_ff, nxt_lanes;
  logic sck_ff, nxt_sck;
  logic cs_n_ff, nxt_cs_n;
  logic [3:0] io_ff, nxt_io;
  logic [3:0] oe_ff, nxt_oe;
  logic done_ff, nxt_done;
  logic busy_ff, nxt_busy;
  logic [3:0] io_s1_ff, nxt_io_s1;
  logic [3:0] io_s2_ff, nxt_io_s2;
  logic [3:0] io_s3_ff, nxt_io_s3;
  logic [3:0] io_in_ff, nxt_io_in;
  logic last_bits;

  // Next enabled phase after the given one, with its length and data
  function automatic void pick(input sfm_state_e from, output sfm_state_e to, output logic [6:0] len,
                      output logic [63:0] sh, output logic [1:0] ln);
    to = SFM_DONE;
    len = 7'h00;
    sh = 64'h0;
    ln = `SFM_LANES_1;
    if (from == SFM_IDLE && CMD_EN_IN) begin
      to = SFM_CMD; len = 7'h08; sh = {CMD_IN, 56'h0}; ln = CMD_LANES_IN;
    end else if ((from == SFM_IDLE || from == SFM_CMD) && OCMD_EN_IN) begin
      to = SFM_OCMD; len = 7'h08; sh = {OCMD_IN, 56'h0}; ln = OCMD_LANES_IN;
    end else if (from != SFM_ADDR && from != SFM_OPT && from != SFM_DATA && ADDR_EN_IN != `SFM_ADDR_NONE) begin
      to = SFM_ADDR; ln = ADDR_LANES_IN;
      if (ADDR_EN_IN == `SFM_ADDR_32) begin
        len = 7'h20; sh = {ADDR_IN, 32'h0};
      end else begin
        len = 7'h18; sh = {ADDR_IN[23:0], 40'h0};
      end
    // option bytes from byte 3 down
    end else if (from != SFM_OPT && from != SFM_DATA && OPT_EN_IN != `SFM_OPD_NONE) begin
      to = SFM_OPT; ln = OPT_LANES_IN; sh = {OPT_IN, 32'h0};
      case (OPT_EN_IN)
        `SFM_OPD_3: len = 7'h08;
        `SFM_OPD_32: len = 7'h10;
        `SFM_OPD_321: len = 7'h18;
        default: len = 7'h20;
      endcase
    end else if (from != SFM_DATA && DATA_EN_IN != `SFM_DATA_NONE) begin
      to = SFM_DATA; ln = DATA_LANES_IN; sh = WDATA_IN;
      case (DATA_EN_IN)
        `SFM_DATA_8: len = DOUBLE_IN ? 7'h10 : 7'h08;
        `SFM_DATA_16: len = DOUBLE_IN ? 7'h20 : 7'h10;
        default: len = DOUBLE_IN ? 7'h40 : 7'h20;
      endcase
    end
  endfunction

  // -------------------------------------------------------------
  // Read lane synchroniser
  // -------------------------------------------------------------
  // Three stages from the pins; a new level counts once stages two and three agree
  always_comb begin
    nxt_io_s1 = IO_IN;
    nxt_io_s2 = io_s1_ff;
    nxt_io_s3 = io_s2_ff;
    nxt_io_in = (io_s2_ff == io_s3_ff) ? io_s3_ff : io_in_ff;
  end

  // Register the synchroniser stages
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      io_s1_ff <= `SFM_RST_LANES;
      io_s2_ff <= `SFM_RST_LANES;
      io_s3_ff <= `SFM_RST_LANES;
      io_in_ff <= `SFM_RST_LANES;
    end else begin
      io_s1_ff <= nxt_io_s1;
      io_s2_ff <= nxt_io_s2;
      io_s3_ff <= nxt_io_s3;
      io_in_ff <= nxt_io_in;
    end
  end

  // -------------------------------------------------------------
  // Frame sequencer
  // -------------------------------------------------------------
  assign last_bits = (cnt_ff + step_of(lanes_ff)) >= len_ff;

  // Next state: each bit time is one low and one high clock cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_len = len_ff;
    nxt_sh = sh_ff;
    nxt_rd = rd_ff;
    nxt_lanes = lanes_ff;
    nxt_sck = sck_ff;
    nxt_cs_n = cs_n_ff;
    nxt_io = io_ff;
    nxt_oe = oe_ff;
    nxt_done = 1'b0;
    case (state_ff)
      SFM_IDLE: begin
        if (START_IN) begin
          nxt_cs_n = 1'b0;
          nxt_cnt = 7'h00;
          pick(SFM_IDLE, nxt_state, nxt_len, nxt_sh, nxt_lanes);
        end
      end
      SFM_CMD, SFM_OCMD, SFM_ADDR, SFM_OPT, SFM_DATA: begin
        if (!sck_ff) begin
          if (lanes_ff == `SFM_LANES_4) begin
            nxt_io = sh_ff[63:60];
            nxt_oe = 4'hf;
            nxt_sh = {sh_ff[59:0], 4'h0};
          end else begin
            nxt_io = {3'h0, sh_ff[63]};
            nxt_oe = 4'h1;
            nxt_sh = {sh_ff[62:0], 1'b0};
          end
          nxt_sck = 1'b1;
        end else begin
          nxt_sck = 1'b0;
          if (state_ff == SFM_DATA) begin
            nxt_rd = (lanes_ff == `SFM_LANES_4) ? {rd_ff[59:0], io_in_ff} : {rd_ff[62:0], io_in_ff[1]};
          end
          if (last_bits) begin
            nxt_cnt = 7'h00;
            pick(state_ff, nxt_state, nxt_len, nxt_sh, nxt_lanes);
          end else begin
            nxt_cnt = cnt_ff + step_of(lanes_ff);
          end
        end
      end
      SFM_DONE: begin
        if (!HOLD_CS_IN) begin
          nxt_cs_n = `SFM_RST_CS;
        end
        nxt_oe = 4'h0;
        nxt_done = 1'b1;
        nxt_state = SFM_IDLE;
      end
      default: nxt_state = SFM_IDLE;
    endcase
    // Busy flag registered alongside the state
    nxt_busy = (nxt_state != SFM_IDLE);
  end

  // Register the sequencer state
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state_ff <= SFM_IDLE;
      cnt_ff <= 7'h00;
      len_ff <= 7'h00;
      sh_ff <= 64'h0;
      rd_ff <= 64'h0;
      lanes_ff <= 2'h0;
      sck_ff <= 1'b0;
      cs_n_ff <= `SFM_RST_CS;
      io_ff <= `SFM_RST_LANES;
      oe_ff <= `SFM_RST_LANES;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      len_ff <= nxt_len;
      sh_ff <= nxt_sh;
      rd_ff <= nxt_rd;
      lanes_ff <= nxt_lanes;
      sck_ff <= nxt_sck;
      cs_n_ff <= nxt_cs_n;
      io_ff <= nxt_io;
      oe_ff <= nxt_oe;
      done_ff <= nxt_done;
      busy_ff <= nxt_busy;
    end
  end

  assign CS_N_OUT = cs_n_ff;
  assign SCK_OUT = sck_ff;
  assign IO_OUT = io_ff;
  assign IO_OE_OUT = oe_ff;
  assign BUSY_OUT = busy_ff;
  assign DONE_OUT = done_ff;
  assign RDATA_OUT = rd_ff;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  // select released after frame
  a_cs_release: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == SFM_DONE && !HOLD_CS_IN) |=> CS_N_OUT) else $error("select not released");
  a_cs_hold: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == SFM_DONE && HOLD_CS_IN) |=> $stable(CS_N_OUT)) else $error("select not held");
  // four lane command drives all lanes
  a_cmd_lanes: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == SFM_CMD && !sck_ff && lanes_ff == `SFM_LANES_4) |=> IO_OE_OUT == 4'hf)
    else $error("command lanes wrong");
  // single lane data drives one lane
  a_data_lanes: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == SFM_DATA && !sck_ff && lanes_ff == `SFM_LANES_1) |=> IO_OE_OUT == 4'h1)
    else $error("data lanes wrong");
  a_cmd_skip: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == SFM_IDLE && START_IN && !CMD_EN_IN) |=> state_ff != SFM_CMD) else $error("command not skipped");
  a_phase_order: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == SFM_DATA) |=> (state_ff != SFM_ADDR && state_ff != SFM_CMD)) else $error("phase order broken");
  a_addr_len: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    ($changed(state_ff) && state_ff == SFM_ADDR && ADDR_EN_IN == `SFM_ADDR_24) |-> len_ff == 7'h18)
    else $error("address length wrong");
  a_no_data: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (DATA_EN_IN == `SFM_DATA_NONE && state_ff != SFM_DATA) |=> state_ff != SFM_DATA) else $error("data phase ran");
  a_opt_len: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    ($changed(state_ff) && state_ff == SFM_OPT && OPT_EN_IN == `SFM_OPD_3) |-> len_ff == 7'h08)
    else $error("option length wrong");

endmodule // sfm_frame
`default_nettype wire

// ### sfm_flash_model.sv
// Serial flash stand-in: records each clock group and answers read lanes
`timescale 1ns/10ps
`default_nettype none
module sfm_flash_model (
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  input wire logic [3:0] oe_in,
  output logic [3:0] io_out
);
  logic [3:0] cap_v[$];
  logic cap_w[$];
  // lane count taken from driven enables
  always @(negedge sck_in) begin
    if (!cs_n_in) begin
      cap_v.push_back(oe_in == 4'hf ? io_in : {3'h0, io_in[0]});
      cap_w.push_back(oe_in == 4'hf);
    end
  end
  // Deselected lanes show the inverse of the last answer
  always_comb io_out = cs_n_in ? 4'h5 : 4'ha;
endmodule // sfm_flash_model
`default_nettype wire

// ### testbench.sv
// Frame sequencer testbench: phase layout, lanes, lengths and select hold
`timescale 1ns/10ps
`default_nettype none
`include "sfm_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  logic clk, rst_n, start, cmd_en, ocmd_en, dbl, hold, cs_n, sck, busy, done;
  logic [3:0] ae, pe, de, io_in, io, io_oe;
  logic [1:0] cl, ol, al, pl, dl;
  logic [63:0] rdata;
  int n_errors, compares;
  logic [3:0] exp_v[$];
  logic exp_w[$];
  localparam logic [63:0] WD = 64'hfedc_ba98_7654_3210;
  localparam logic [31:0] AD = 32'h1234_5678;
  localparam logic [31:0] OP = 32'h89ab_cdef;
  sfm_frame dut_u (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .START_IN(start), .CMD_EN_IN(cmd_en),
    .OCMD_EN_IN(ocmd_en), .ADDR_EN_IN(ae), .OPT_EN_IN(pe), .DATA_EN_IN(de), .DOUBLE_IN(dbl),
    .CMD_LANES_IN(cl), .OCMD_LANES_IN(ol), .ADDR_LANES_IN(al), .OPT_LANES_IN(pl), .DATA_LANES_IN(dl),
    .HOLD_CS_IN(hold), .CMD_IN(8'hc3), .OCMD_IN(8'h5a), .ADDR_IN(AD), .OPT_IN(OP), .WDATA_IN(WD),
    .IO_IN(io_in), .CS_N_OUT(cs_n), .SCK_OUT(sck), .IO_OUT(io), .IO_OE_OUT(io_oe), .BUSY_OUT(busy),
    .DONE_OUT(done), .RDATA_OUT(rdata));
  sfm_flash_model flash_u (.sck_in(sck), .cs_n_in(cs_n), .io_in(io), .oe_in(io_oe), .io_out(io_in));
  // ---------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // Ends the run with the verdict
  task automatic conclude();
    $display("Comparisons %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Queues the expected clock groups of one phase, MSB first
  task automatic add(input logic [63:0] v, input int nb, input logic four);
    int st;
    st = four ? 4 : 1;
    for (int i = nb - st; i >= 0; i -= st) begin
      exp_v.push_back(four ? 4'((v >> i) & 64'hf) : {3'h0, v[i]});
      exp_w.push_back(four);
    end
  endtask
  // Runs one frame; fw holds a four-lane flag per phase, command first
  task automatic frame(input logic c, o, input logic [3:0] a, p, d, input logic db, h, input logic [4:0] fw);
    int n, k, nb;
    exp_v = {};
    exp_w = {};
    flash_u.cap_v = {};
    flash_u.cap_w = {};
    @(posedge clk);
    #5 {cmd_en, ocmd_en, ae, pe, de, dbl, hold} = {c, o, a, p, d, db, h};
    cl = fw[4] ? `SFM_LANES_4 : `SFM_LANES_1;
    ol = fw[3] ? `SFM_LANES_4 : `SFM_LANES_1;
    al = fw[2] ? `SFM_LANES_4 : `SFM_LANES_1;
    pl = fw[1] ? `SFM_LANES_4 : `SFM_LANES_1;
    dl = fw[0] ? `SFM_LANES_4 : `SFM_LANES_1;
    start = 1;
    if (c) add(64'hc3, 8, fw[4]);
    if (o) add(64'h5a, 8, fw[3]);
    if (a != 0) add(a == `SFM_ADDR_32 ? AD : AD & 32'hff_ffff, a == `SFM_ADDR_32 ? 32 : 24, fw[2]);
    nb = p == `SFM_OPD_3 ? 8 : p == `SFM_OPD_32 ? 16 : p == `SFM_OPD_321 ? 24 : 32;
    if (p != 0) add(OP >> (32 - nb), nb, fw[1]);
    nb = (d == `SFM_DATA_8 ? 8 : d == `SFM_DATA_16 ? 16 : 32) * (db ? 2 : 1);
    if (d != 0) add(WD >> (64 - nb), nb, fw[0]);
    n = exp_v.size();
    @(posedge clk);
    #5 start = 0;
    `CHK(busy, 1'b1)
    k = 0;
    do begin
      @(posedge clk);
      #5 k++;
    end while (done !== 1'b1 && k < 400);
    if (k >= 400) begin
      n_errors++;
      conclude();
    end
    `CHK(k, 2 * n + 1)
    `CHK(cs_n, !h)
    `CHK(busy, 1'b0)
    `CHK(flash_u.cap_v.size(), n)
    foreach (exp_v[i]) begin
      `CHK(flash_u.cap_v[i], exp_v[i])
      `CHK(flash_u.cap_w[i], exp_w[i])
    end
    repeat (3) @(posedge clk);
    #5 `CHK(cs_n, !h)
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, start, cmd_en, ocmd_en, dbl, hold, ae, pe, de, cl, ol, al, pl, dl} = '0;
    n_errors = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    #5 `CHK({cs_n, sck, busy, done, io_oe}, 8'h80)
    rst_n = 1;
    frame(1, 1, `SFM_ADDR_24, `SFM_OPD_3, `SFM_DATA_8, 0, 0, 5'h00);
    frame(1, 1, `SFM_ADDR_32, `SFM_OPD_3210, `SFM_DATA_32, 1, 1, 5'h1f);
    frame(0, 0, `SFM_ADDR_NONE, `SFM_OPD_NONE, `SFM_DATA_NONE, 0, 0, 5'h1f);
    frame(1, 0, `SFM_ADDR_24, `SFM_OPD_32, `SFM_DATA_16, 1, 1, 5'h15);
    frame(0, 1, `SFM_ADDR_32, `SFM_OPD_321, `SFM_DATA_NONE, 0, 0, 5'h0a);
    frame(1, 1, `SFM_ADDR_NONE, `SFM_OPD_NONE, `SFM_DATA_8, 0, 0, 5'h11);
    `CHK(rdata[7:0], 8'haa)
    conclude();
  end
endmodule // testbench
`default_nettype wire
